/* File: mfgp_consts.svh */
// Purpose: constants for the multifunction pin bank
// Assumes: 16-bit register words at 8-bit word addresses
// Notes: per-pin registers sit at base plus pin index
`ifndef MFGP_CONSTS_SVH
`define MFGP_CONSTS_SVH
`define MFGP_NPIN 16
`define MFGP_A_CFG 8'h00
`define MFGP_A_MASK 8'h10
`define MFGP_A_GOUT 8'h20
`define MFGP_A_GIN 8'h21
`define MFGP_A_VSEL 8'h22
`define MFGP_A_STKY 8'h23
`define MFGP_A_AEN 8'h24
`define MFGP_F_MODE 0
`define MFGP_F_EN 4
`define MFGP_F_OD 5
`define MFGP_F_PD 6
`define MFGP_F_INV 7
`define MFGP_F_SEL 8
`define MFGP_STKY_HO 8
`define MFGP_CFG_RST 16'h0000
`define MFGP_MASK_RST 16'h0000
`define MFGP_VSEL_RST 2'h3
`endif

/* File: mfgp_pkg.sv */
// Purpose: types for the multifunction pin bank
// Assumes: nothing beyond the constants header
// Notes: codes 4'he and 4'hf are illegal and act as plain input
package mfgp_pkg;
  typedef enum logic [3:0] {
    md_in = 4'h0, md_out = 4'h1, md_los = 4'h2, md_lol = 4'h3,
    md_lols = 4'h4, md_ho = 4'h5, md_hos = 4'h6, md_alert = 4'h7,
    md_odis = 4'h8, md_clkin = 4'h9, md_msel = 4'ha, md_inc = 4'hb,
    md_dec = 4'hc, md_disq = 4'hd
  } mfgp_mode_t;
  typedef enum logic [1:0] {
    lv_1v5 = 2'h0, lv_1v8 = 2'h1, lv_2v5 = 2'h2, lv_3v3 = 2'h3
  } mfgp_level_t;
endpackage : mfgp_pkg

/* File: mfgp_pins.sv */
// Purpose: sixteen multifunction pins with alarm, control and strobe modes
// Assumes: one 25 MHz clock, synchronous active-high reset
// Notes: loop inputs come from same-clock logic; pins are asynchronous
//
// Summary of operation
// - sixteen pins, index 0 to 15, each with own registers.
// - each pin runs exactly one mode chosen from its config.
// - pin modes other than input act only once the reset sequence has finished.
// - input mode shows pin level in a status register; default mode.
// - output mode drives the level held in a writable register.
// - pins with equal alarm configuration show equal outputs.
// - loss-of-signal mode follows the live monitor alarm, invertible.
// - live loss-of-lock is high while selected loop is unlocked.
// - sticky loss-of-lock sets on any lock change until cleared.
// - live holdover is high while selected digital loop holds over.
// - sticky holdover sets on entry or exit until cleared.
// - alert mode is OR of enabled sticky bits, invertible.
// - high disable pin stops selected output clocks; low enables.
// - each disable pin controls any subset of outputs by mask.
// - clock input mode routes pin unless its stage is full.
// - manual select picks high or low priority reference.
// - rising edges increment or decrement the selected oscillator.
// - high disqualify pin disqualifies the selected reference.
// - one global setting gives the pin supply level.
// - enabled output pins drive open-drain low only or push-pull.
// - per-pin pull select, pull-up by default, pull-down option.
// - sticky bits hold until cleared; only live status self-clears.
`timescale 1ns/1ps
`include "mfgp_consts.svh"

module mfgp_pins
  import mfgp_pkg::*;
#(
  parameter int NPIN = `MFGP_NPIN,
  parameter int NREF = 4,
  parameter int NDL = 2,
  parameter int NOUT = 4
) (
  input wire logic clock,
  input wire logic reset,
  input wire logic [7:0] reg_addr,
  input wire logic [15:0] reg_wdata,
  input wire logic reg_wr,
  input wire logic reg_rd,
  output logic [15:0] reg_rdata,
  input wire logic [NPIN-1:0] pin_i,
  output logic [NPIN-1:0] pin_o,
  output logic [NPIN-1:0] pin_oe,
  output logic [NPIN-1:0] pin_pull_dn,
  output logic [1:0] pin_level,
  input wire logic init_done,
  input wire logic [NREF-1:0] ref_los,
  input wire logic [NDL:0] loop_locked,
  input wire logic [NDL-1:0] loop_holdover,
  input wire logic [NPIN-1:0] se_stage_full,
  output logic [NPIN-1:0] se_clk,
  output logic [NOUT-1:0] clk_out_dis,
  output logic [NDL-1:0] man_sel_act,
  output logic [NDL-1:0] man_sel_hi,
  output logic [NDL-1:0] dco_inc,
  output logic [NDL-1:0] dco_dec,
  output logic [NREF-1:0] ref_disq
);

  localparam int NLK = NDL + 1; // digital loops then the analog loop

  logic [15:0] cfg_q [NPIN], mask_q [NPIN], sel1h [NPIN];
  logic [15:0] gout_q, stky_q, aen_q, rdata_q, rdata_d;
  mfgp_level_t vsel_q;
  logic [NLK-1:0] lk_prev_q, lol_w;
  logic [NDL-1:0] ho_prev_q;
  logic [15:0] los_pad, lol_pad, ho_pad, chg16;
  logic alert;
  logic [NPIN-1:0] lvl_v, rise_v, drv_v, isout_v, act_v;
  mfgp_mode_t md_a [NPIN];
  logic [NPIN-1:0] pin_o_q, pin_oe_q, pull_q, se_q;
  logic [NOUT-1:0] dis_q, dis_d;
  logic [NDL-1:0] msa_q, msa_d, msh_q, msh_d;
  logic [NDL-1:0] inc_q, inc_d, dec_q, dec_d;
  logic [NREF-1:0] dq_q, dq_d;

  // source vectors widened so a 4-bit select never indexes out of range
  assign lol_w = ~loop_locked;
  assign los_pad = 16'(ref_los);
  assign lol_pad = 16'(lol_w);
  assign ho_pad = 16'(loop_holdover);
  assign chg16 = (16'(loop_holdover ^ ho_prev_q) << `MFGP_STKY_HO)
               | 16'(loop_locked ^ lk_prev_q);

  assign alert = |(stky_q & aen_q);

  for (genvar g = 0; g < NPIN; g++) begin : g_pin
    logic s1_q, s2_q, s3_q, lv_q;
    logic [3:0] sel;
    logic inv, al, drv, isout;
    mfgp_mode_t md;
    assign md = mfgp_mode_t'(cfg_q[g][`MFGP_F_MODE +: 4]);
    assign sel = cfg_q[g][`MFGP_F_SEL +: 4];
    assign inv = cfg_q[g][`MFGP_F_INV];
    assign sel1h[g] = 16'h0001 << sel;
    assign md_a[g] = md;

    // three-stage sync; s1 feeds only s2
    always_ff @(posedge clock) begin
      if (reset) begin
        s1_q <= 1'h1; // pull-up idle level, so no false edge after reset
        s2_q <= 1'h1;
        s3_q <= 1'h1;
        lv_q <= 1'h1;
      end else begin
        s1_q <= pin_i[g];
        s2_q <= s1_q;
        s3_q <= s2_q;
        if (s2_q == s3_q) begin
          lv_q <= s3_q;
        end
      end
    end
    assign lvl_v[g] = lv_q;
    assign rise_v[g] = (s2_q == s3_q) && s3_q && !lv_q;

    always_comb begin
      al = 1'h0;
      isout = 1'h1;
      unique case (md)
        md_out: al = 1'h0;
        md_los: al = los_pad[sel];         // live monitor alarm
        md_lol: al = lol_pad[sel];         // high while unlocked
        md_lols: al = stky_q[{1'h0, sel[2:0]}]; // sticky lock change
        md_ho: al = ho_pad[sel];           // live holdover
        md_hos: al = stky_q[{1'h1, sel[2:0]}]; // sticky holdover
        md_alert: al = alert;
        md_in, md_odis, md_clkin, md_msel, md_inc, md_dec, md_disq:
          isout = 1'h0;
        default: isout = 1'h0; // illegal codes behave as plain input
      endcase
    end
    // plain output level; alarms take optional inversion
    assign drv = (md == md_out) ? gout_q[g] : (al ^ inv);
    assign drv_v[g] = drv;
    assign isout_v[g] = isout;
    assign act_v[g] = init_done && cfg_q[g][`MFGP_F_EN];
  end

  // pin drive: open-drain pulls low only, else push-pull
  always_ff @(posedge clock) begin
    if (reset) begin
      pin_o_q <= '0;
      pin_oe_q <= '0;
    end else begin
      for (int p = 0; p < NPIN; p++) begin
        if (act_v[p] && isout_v[p]) begin
          if (cfg_q[p][`MFGP_F_OD]) begin
            pin_o_q[p] <= 1'h0;
            pin_oe_q[p] <= !drv_v[p];
          end else begin
            pin_o_q[p] <= drv_v[p];
            pin_oe_q[p] <= 1'h1;
          end
        end else begin
          pin_o_q[p] <= 1'h0;
          pin_oe_q[p] <= 1'h0;
        end
      end
    end
  end

  // gather input-mode requests from all pins onto their targets
  always_comb begin
    dis_d = '0;
    msa_d = '0;
    msh_d = '0;
    inc_d = '0;
    dec_d = '0;
    dq_d = '0;
    for (int p = 0; p < NPIN; p++) begin
      if (act_v[p]) begin
        if (md_a[p] == md_odis && lvl_v[p]) begin
          dis_d = dis_d | mask_q[p][NOUT-1:0];
        end
        if (md_a[p] == md_msel) begin
          msa_d = msa_d | sel1h[p][NDL-1:0];
          if (lvl_v[p]) begin
            msh_d = msh_d | sel1h[p][NDL-1:0];
          end
        end
        if (md_a[p] == md_inc && rise_v[p]) begin
          inc_d = inc_d | sel1h[p][NDL-1:0];
        end
        if (md_a[p] == md_dec && rise_v[p]) begin
          dec_d = dec_d | sel1h[p][NDL-1:0];
        end
        if (md_a[p] == md_disq && lvl_v[p]) begin
          dq_d = dq_d | sel1h[p][NREF-1:0];
        end
      end
    end
  end

  // control outputs registered so every port leaves a flop
  always_ff @(posedge clock) begin
    if (reset) begin
      dis_q <= '0;
      msa_q <= '0;
      msh_q <= '0;
      inc_q <= '0;
      dec_q <= '0;
      dq_q <= '0;
      se_q <= '0;
      pull_q <= '0;
    end else begin
      dis_q <= dis_d;
      msa_q <= msa_d;
      msh_q <= msh_d;
      inc_q <= inc_d;
      dec_q <= dec_d;
      dq_q <= dq_d;
      for (int p = 0; p < NPIN; p++) begin
        se_q[p] <= act_v[p] && md_a[p] == md_clkin
                   && !se_stage_full[p] && lvl_v[p];
        pull_q[p] <= cfg_q[p][`MFGP_F_PD];
      end
    end
  end

  // configuration registers; writes land the cycle after the strobe
  always_ff @(posedge clock) begin
    if (reset) begin
      for (int p = 0; p < NPIN; p++) begin
        cfg_q[p] <= `MFGP_CFG_RST; // input mode default
        mask_q[p] <= `MFGP_MASK_RST;
      end
      gout_q <= '0;
      aen_q <= '0;
      vsel_q <= mfgp_level_t'(`MFGP_VSEL_RST);
    end else if (reg_wr) begin
      for (int p = 0; p < NPIN; p++) begin
        if (reg_addr == `MFGP_A_CFG + 8'(p)) begin
          cfg_q[p] <= reg_wdata;
        end
        if (reg_addr == `MFGP_A_MASK + 8'(p)) begin
          mask_q[p] <= reg_wdata;
        end
      end
      if (reg_addr == `MFGP_A_GOUT) begin
        gout_q <= reg_wdata;
      end
      if (reg_addr == `MFGP_A_AEN) begin
        aen_q <= reg_wdata;
      end
      if (reg_addr == `MFGP_A_VSEL) begin
        vsel_q <= mfgp_level_t'(reg_wdata[1:0]);
      end
    end
  end

  // sticky: a change in the clear cycle still sets the bit
  always_ff @(posedge clock) begin
    if (reset) begin
      stky_q <= '0;
      lk_prev_q <= '1;
      ho_prev_q <= '0;
    end else begin
      lk_prev_q <= loop_locked;
      ho_prev_q <= loop_holdover;
      if (reg_wr && reg_addr == `MFGP_A_STKY) begin
        stky_q <= (stky_q & ~reg_wdata) | chg16;
      end else begin
        stky_q <= stky_q | chg16;
      end
    end
  end

  // read mux; unmapped addresses read zero
  always_comb begin
    rdata_d = 16'h0000;
    if (reg_addr[7:4] == 4'h0) begin
      rdata_d = cfg_q[reg_addr[3:0]];
    end else if (reg_addr[7:4] == 4'h1) begin
      rdata_d = mask_q[reg_addr[3:0]];
    end else if (reg_addr == `MFGP_A_GOUT) begin
      rdata_d = gout_q;
    end else if (reg_addr == `MFGP_A_GIN) begin
      rdata_d = 16'(lvl_v); // captured levels
    end else if (reg_addr == `MFGP_A_VSEL) begin
      rdata_d = 16'(vsel_q);
    end else if (reg_addr == `MFGP_A_STKY) begin
      rdata_d = stky_q;
    end else if (reg_addr == `MFGP_A_AEN) begin
      rdata_d = aen_q;
    end
  end

  // read data stands only in the cycle after the strobe
  always_ff @(posedge clock) begin
    if (reset || !reg_rd) begin
      rdata_q <= '0;
    end else begin
      rdata_q <= rdata_d;
    end
  end

  assign reg_rdata = rdata_q;
  assign pin_o = pin_o_q;
  assign pin_oe = pin_oe_q;
  assign pin_pull_dn = pull_q;
  assign pin_level = vsel_q;
  assign se_clk = se_q;
  assign clk_out_dis = dis_q;
  assign man_sel_act = msa_q;
  assign man_sel_hi = msh_q;
  assign dco_inc = inc_q;
  assign dco_dec = dec_q;
  assign ref_disq = dq_q;

  // checks watch the pins the bench exercises; the logic is shared
  default clocking cb @(posedge clock);
  endclocking
  default disable iff (reset);

  property p_quiet;
    !init_done |=> pin_oe == '0;
  endproperty
  a_quiet: assert property (p_quiet)
    else $error("pin driven before reset sequence done");
  property p_outdrv;
    act_v[1] && md_a[1] == md_out && !cfg_q[1][`MFGP_F_OD]
      |=> pin_oe[1] && pin_o[1] == $past(gout_q[1]);
  endproperty
  a_outdrv: assert property (p_outdrv)
    else $error("output mode pin not at register level");
  property p_odrain;
    act_v[1] && isout_v[1] && cfg_q[1][`MFGP_F_OD] |=> !pin_o[1];
  endproperty
  a_odrain: assert property (p_odrain)
    else $error("open-drain pin drove high");
  property p_same;
    cfg_q[2] == cfg_q[3] && md_a[2] >= md_los && md_a[2] <= md_alert
      |=> pin_o[2] == pin_o[3] && pin_oe[2] == pin_oe[3];
  endproperty
  a_same: assert property (p_same)
    else $error("equal alarm pins differ");
  property p_hold;
    stky_q[0] && !(reg_wr && reg_addr == `MFGP_A_STKY && reg_wdata[0])
      |=> stky_q[0];
  endproperty
  a_hold: assert property (p_hold)
    else $error("sticky bit dropped without clear");
  property p_lkset;
    loop_locked[0] != lk_prev_q[0] |=> stky_q[0];
  endproperty
  a_lkset: assert property (p_lkset)
    else $error("lock change not latched");
  property p_alert;
    act_v[6] && md_a[6] == md_alert && !cfg_q[6][`MFGP_F_INV]
      && !cfg_q[6][`MFGP_F_OD] && |(stky_q & aen_q) |=> pin_o[6];
  endproperty
  a_alert: assert property (p_alert)
    else $error("alert pin low with enabled sticky set");
  property p_sync;
    rise_v[0] |-> $past(pin_i[0], 2) && $past(pin_i[0], 3)
      && !lvl_v[0];
  endproperty
  a_sync: assert property (p_sync)
    else $error("edge seen without synchronised level");
  property p_odis;
    act_v[7] && md_a[7] == md_odis && mask_q[7][0] && lvl_v[7]
      |=> clk_out_dis[0];
  endproperty
  a_odis: assert property (p_odis)
    else $error("disable pin high but output still enabled");
  property p_gin;
    reg_rd && reg_addr == `MFGP_A_GIN |=> reg_rdata == 16'($past(lvl_v));
  endproperty
  a_gin: assert property (p_gin)
    else $error("input status read wrong");
  c_alert: cover property (act_v[6] && md_a[6] == md_alert && alert);
  c_inc: cover property (|dco_inc);
  c_odis: cover property (|clk_out_dis);
  c_clr: cover property (reg_wr && reg_addr == `MFGP_A_STKY && |stky_q);

endmodule // mfgp_pins

/* File: mfgp_board.sv */
// Purpose: board-side model that drives and senses the pins
// Assumes: the board drives only the pins flagged in bd_oe
// Notes: a clash shows as unknown so that it cannot pass as a match
`timescale 1ns/1ps

module mfgp_board #(
  parameter int NPIN = 16
) (
  input wire logic [NPIN-1:0] pin_o,
  input wire logic [NPIN-1:0] pin_oe,
  input wire logic [NPIN-1:0] pin_pull_dn,
  input wire logic [NPIN-1:0] bd_val,
  input wire logic [NPIN-1:0] bd_oe,
  output logic [NPIN-1:0] pin_w
);
  // resolve each wire from both drivers and the selected pull
  always_comb begin
    for (int k = 0; k < NPIN; k++) begin
      if (pin_oe[k] && bd_oe[k])
        pin_w[k] = 1'hx;
      else if (bd_oe[k])
        pin_w[k] = bd_val[k];
      else if (pin_oe[k])
        pin_w[k] = pin_o[k];
      else
        pin_w[k] = ~pin_pull_dn[k];
    end
  end
endmodule // mfgp_board

/* File: testbench.sv */
// Purpose: self-checking bench for the multifunction pin bank
// Assumes: register map and latencies as handed over by the designer
// Notes: checks sample on the falling edge, clear of update races
`timescale 1ns/1ps
`include "mfgp_consts.svh"

module testbench
  import mfgp_pkg::*;
;
  logic clock, reset, reg_wr, reg_rd, init_done;
  logic [7:0] reg_addr;
  logic [15:0] reg_wdata, reg_rdata, pin_i, pin_o, pin_oe, pin_pull_dn;
  logic [15:0] se_stage_full, se_clk, bd_val, bd_oe;
  logic [1:0] pin_level, man_sel_act, man_sel_hi, dco_inc, dco_dec;
  logic [1:0] loop_holdover;
  logic [3:0] ref_los, clk_out_dis, ref_disq;
  logic [2:0] loop_locked;
  int err_count, samples_checked, inc_n, dec_n;

  mfgp_pins i_mfgp_pins (
    .clock(clock), .reset(reset), .reg_addr(reg_addr),
    .reg_wdata(reg_wdata), .reg_wr(reg_wr), .reg_rd(reg_rd),
    .reg_rdata(reg_rdata), .pin_i(pin_i), .pin_o(pin_o),
    .pin_oe(pin_oe), .pin_pull_dn(pin_pull_dn), .pin_level(pin_level),
    .init_done(init_done), .ref_los(ref_los), .loop_locked(loop_locked),
    .loop_holdover(loop_holdover), .se_stage_full(se_stage_full),
    .se_clk(se_clk), .clk_out_dis(clk_out_dis),
    .man_sel_act(man_sel_act), .man_sel_hi(man_sel_hi),
    .dco_inc(dco_inc), .dco_dec(dco_dec), .ref_disq(ref_disq)
  );

  mfgp_board i_mfgp_board (
    .pin_o(pin_o), .pin_oe(pin_oe), .pin_pull_dn(pin_pull_dn),
    .bd_val(bd_val), .bd_oe(bd_oe), .pin_w(pin_i)
  );

  initial begin
    clock = 1'h0;
    forever #20 clock = ~clock;
  end

  // strobes are one cycle wide, so counting them shows each edge once
  always @(negedge clock) begin
    inc_n += dco_inc[1];
    dec_n += dco_dec[1];
  end

  task automatic chk(input logic [15:0] e, input logic [15:0] a);
    samples_checked++;
    if (a !== e) begin
      $display("ERROR t=%0t exp=%h got=%h", $time, e, a);
      err_count++;
    end
  endtask

  task automatic wr(input logic [7:0] a, input logic [15:0] d);
    @(posedge clock);
    reg_addr <= a;
    reg_wdata <= d;
    reg_wr <= 1'h1;
    @(posedge clock);
    reg_wr <= 1'h0;
  endtask

  task automatic rdc(input logic [7:0] a, input logic [15:0] m, e);
    @(posedge clock);
    reg_addr <= a;
    reg_rd <= 1'h1;
    @(posedge clock);
    reg_rd <= 1'h0;
    @(negedge clock);
    chk(e, reg_rdata & m);
  endtask

  task automatic cfg(input logic [7:0] k, input mfgp_mode_t m,
                     input logic [3:0] s, f);
    wr(`MFGP_A_CFG + k, {4'h0, s, f, m});
  endtask

  // long enough for the synchroniser and the output register
  task automatic settle();
    repeat (8) @(posedge clock);
    @(negedge clock);
  endtask

  task automatic test_done();
    if (err_count == 0 && samples_checked > 0)
      $display("ALL TESTS PASSED");
    else
      $display("TESTS FAILED");
    $finish;
  endtask

  initial begin
    reset = 1'h1;
    init_done = 1'h0;
    reg_addr = 8'h00;
    reg_wdata = 16'h0000;
    reg_wr = 1'h0;
    reg_rd = 1'h0;
    ref_los = 4'h0;
    loop_locked = 3'h7;
    loop_holdover = 2'h0;
    se_stage_full = 16'h0000;
    bd_val = 16'h0000;
    bd_oe = 16'h1f81;
    err_count = 0;
    samples_checked = 0;
    repeat (6) @(posedge clock);
    reset <= 1'h0;
    @(negedge clock);
    chk(16'h0003, 16'(pin_level));
    chk(16'h0000, pin_pull_dn | pin_oe);
    rdc(`MFGP_A_CFG + 8'h5, 16'hffff, `MFGP_CFG_RST);
    rdc(`MFGP_A_MASK, 16'hffff, `MFGP_MASK_RST);
    rdc(8'hff, 16'hffff, 16'h0000);
    wr(`MFGP_A_VSEL, 16'h0001);
    rdc(`MFGP_A_VSEL, 16'h0003, 16'h0001);
    chk(16'h0001, 16'(pin_level));
    // output mode held off until the start-up sequence ends
    cfg(8'h1, md_out, 4'h0, 4'h1);
    wr(`MFGP_A_GOUT, 16'h0002);
    settle();
    chk(16'h0000, 16'(pin_oe[1]));
    @(posedge clock);
    init_done <= 1'h1;
    settle();
    chk(16'h0001, 16'(pin_oe[1] & pin_i[1]));
    cfg(8'h1, md_out, 4'h0, 4'h3);
    settle();
    chk(16'h0001, 16'({pin_oe[1], pin_i[1]}));
    cfg(8'h1, md_out, 4'h0, 4'h7);
    wr(`MFGP_A_GOUT, 16'h0000);
    settle();
    chk(16'h0006, 16'({pin_pull_dn[1], pin_oe[1], pin_i[1]}));
    // input level seen through the status register
    cfg(8'h0, md_in, 4'h0, 4'h1);
    @(posedge clock);
    bd_val <= 16'h0001;
    settle();
    rdc(`MFGP_A_GIN, 16'h0001, 16'h0001);
    @(posedge clock);
    bd_val <= 16'h0000;
    settle();
    rdc(`MFGP_A_GIN, 16'h0001, 16'h0000);
    // two pins on the same monitor, one then inverted
    cfg(8'h2, md_los, 4'h1, 4'h1);
    cfg(8'h3, md_los, 4'h1, 4'h1);
    @(posedge clock);
    ref_los <= 4'h2;
    settle();
    chk(16'h0003, 16'(pin_o[3:2]));
    cfg(8'h3, md_los, 4'h1, 4'h9);
    @(posedge clock);
    ref_los <= 4'h0;
    settle();
    chk(16'h0002, 16'(pin_o[3:2]));
    cfg(8'h4, md_lol, 4'h1, 4'h1);
    @(posedge clock);
    loop_locked <= 3'h5;
    settle();
    chk(16'h0001, 16'(pin_o[4]));
    @(posedge clock);
    loop_locked <= 3'h7;
    settle();
    chk(16'h0000, 16'(pin_o[4]));
    // sticky lock and holdover bits, alert fed by holdover only
    wr(`MFGP_A_STKY, 16'hffff);
    wr(`MFGP_A_AEN, 16'h0100);
    cfg(8'h4, md_lols, 4'h0, 4'h1);
    cfg(8'h6, md_alert, 4'h0, 4'h1);
    @(posedge clock);
    loop_locked <= 3'h6;
    @(posedge clock);
    loop_locked <= 3'h7;
    settle();
    chk(16'h0001, 16'({pin_o[6], pin_o[4]}));
    rdc(`MFGP_A_STKY, 16'h0107, 16'h0001);
    @(posedge clock);
    loop_holdover <= 2'h1;
    settle();
    chk(16'h0003, 16'({pin_o[6], pin_o[4]}));
    wr(`MFGP_A_STKY, 16'h0100);
    settle();
    chk(16'h0001, 16'({pin_o[6], pin_o[4]}));
    wr(`MFGP_A_STKY, 16'h0001);
    settle();
    chk(16'h0000, 16'(pin_o[4]));
    cfg(8'h5, md_ho, 4'h0, 4'h1);
    settle();
    chk(16'h0001, 16'(pin_o[5]));
    cfg(8'h5, md_hos, 4'h0, 4'h9);
    settle();
    chk(16'h0001, 16'(pin_o[5]));
    @(posedge clock);
    loop_holdover <= 2'h0;
    settle();
    chk(16'h0000, 16'(pin_o[5]));
    // control inputs driven by the board
    wr(`MFGP_A_MASK + 8'h7, 16'h0005);
    cfg(8'h7, md_odis, 4'h0, 4'h1);
    cfg(8'h8, md_msel, 4'h0, 4'h1);
    cfg(8'h9, md_disq, 4'h2, 4'h1);
    cfg(8'ha, md_clkin, 4'h0, 4'h1);
    @(posedge clock);
    bd_val <= 16'h0780;
    settle();
    chk(16'h0005, 16'(clk_out_dis));
    chk(16'h0003, 16'({man_sel_act[0], man_sel_hi[0]}));
    chk(16'h0004, 16'(ref_disq));
    chk(16'h0001, 16'(se_clk[10]));
    @(posedge clock);
    bd_val <= 16'h0400;
    se_stage_full <= 16'h0400;
    settle();
    chk(16'h0000, 16'(clk_out_dis));
    chk(16'h0002, 16'({man_sel_act[0], man_sel_hi[0]}));
    chk(16'h0000, 16'(ref_disq));
    chk(16'h0000, 16'(se_clk[10]));
    // one strobe per rising edge, none on the falling edge
    cfg(8'hb, md_inc, 4'h1, 4'h1);
    cfg(8'hc, md_dec, 4'h1, 4'h1);
    inc_n = 0;
    dec_n = 0;
    @(posedge clock);
    bd_val <= 16'h1800;
    settle();
    @(posedge clock);
    bd_val <= 16'h0000;
    settle();
    chk(16'h0001, 16'(inc_n));
    chk(16'h0001, 16'(dec_n));
    test_done();
  end

  // the sequence needs well under a thousand cycles
  initial begin
    repeat (4000) @(posedge clock);
    err_count++;
    test_done();
  end
endmodule // testbench
